// ### logic/setup_word_defines.vh
// constants for the converter setup word block
`ifndef SETUP_WORD_DEFINES_VH
`define SETUP_WORD_DEFINES_VH

// ----------------------------------------
// commands (upper nibble of a frame)
// ----------------------------------------
`define CMD_SEL_CH0      4'h0
`define CMD_SEL_CH1      4'h1
`define CMD_WAKE_UP      4'hb
`define CMD_READ_SETUP   4'hc
`define CMD_READ_DATA    4'hd
`define CMD_WRITE_SETUP  4'he
`define CMD_DEFAULT      4'hf

// ----------------------------------------
// setup word fields
// ----------------------------------------
`define SW_AUTO_CHAN     11
`define SW_CLK_SEL       10
`define SW_TRIG_MANUAL   9
`define SW_SPARE         8
`define SW_POL_LOW       7
`define SW_FUNC_EOC      6
`define SW_PIN_OUTPUT    5
`define SW_AUTONAP_OFF   4
`define SW_NAP_OFF       3
`define SW_DEEP_OFF      2
`define SW_TAG_EN        1
`define SW_NORMAL        0
`define SW_RESET_VAL     12'hfff
`define SW_RESET_SINGLE  12'hffd

// ----------------------------------------
// frame timing in serial clocks; auto trigger delay in reference clocks
// ----------------------------------------
`define CMD_BITS         5'd4
`define FRAME_BITS       5'd16
`define TAG_BIT_POS      5'd17
`define AUTO_TRIG_DELAY  3'd4

`endif

// ### logic/edge_sync.v
// two-flop synchroniser with edge outputs
`timescale 1ns/1ns
module edge_sync
(
    // clock and reset
    input  wire ref_clk,
    input  wire resetn,
    // pin side
    input  wire pin_in,
    // synchronised side
    output wire level,
    output wire rise,
    output wire fall
);
    reg       meta_ff;
    reg       sync_ff;
    reg       last_ff;
    reg [1:0] fill_ff;
    wire      primed;

    // stages run through reset so the level matches the pin on release
    always @(posedge ref_clk)
    begin
        meta_ff <= pin_in;
        sync_ff <= meta_ff;
        last_ff <= sync_ff;
    end

    // edges held off until stages refill; short resets give no false edge
    always @(posedge ref_clk)
    begin
        if (!resetn)
            fill_ff <= 2'b00;
        else if (fill_ff != 2'b11)
            fill_ff <= fill_ff + 2'b01;
    end

    assign primed = (fill_ff == 2'b11);
    assign level  = sync_ff;
    assign rise   = sync_ff & ~last_ff & primed;
    assign fall   = ~sync_ff & last_ff & primed;
endmodule // edge_sync

// ### logic/converter_setup_word.v
// serial command decoder and converter setup word
`timescale 1ns/1ns
`include "setup_word_defines.vh"

// Function
// - read command returns the setup word
// - read-back ignores start input, pin quiet
// - read word: four result bits, twelve setup
// - bit 11 selects manual or auto channels
// - bit 10 selects serial/2 or oscillator
// - bit 9 auto trigger or start-input edge
// - auto trigger ignores auto-nap bit
// - bit 7 sets status pin polarity
// - bit 6 selects interrupt or end-of-conversion
// - bit 5 clear makes pin chain input
// - bit 4 clear enables auto-nap
// - bit 3 nap, wake forces one
// - bit 2 deep sleep, wake forces one
// - bit 1 enables tag at clock 17
// - single-channel part: tag bit reads zero
// - setup write lands on sixteenth falling edge
// - reset loads all ones; single-channel part clears tag
module converter_setup_word
#(
    parameter DUAL_CHANNEL = 1
)
(
    // clock and reset
    input  wire        ref_clk,
    input  wire        resetn,
    // serial port pins
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        sdi,
    output reg         sdo,
    output reg         sdo_oe,
    // conversion core side
    input  wire [15:0] result_word,
    input  wire        result_chan,
    input  wire        eoc_active,
    input  wire        int_active,
    input  wire        convert_start_input,
    // status pin (three signals and chain data)
    input  wire        status_pin_in,
    output reg         status_pin_out,
    output reg         status_pin_oe,
    output wire        chain_data_input,
    // decoded controls
    output wire [11:0] setup_word,
    output wire        auto_channel,
    output wire        clk_from_osc,
    output wire        manual_trigger,
    output reg         start_conversion,
    output wire        auto_nap_en,
    output wire        nap_en,
    output wire        deep_en,
    output wire        tag_en,
    output reg         soft_reset,
    output reg         chan_sel_valid,
    output reg         chan_sel
);
    localparam [11:0] RESET_WORD = DUAL_CHANNEL ? `SW_RESET_VAL : `SW_RESET_SINGLE;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire sclk_lvl, sclk_fall, cs_lvl, cs_fall, cs_rise;
    wire sdi_lvl, cst_fall, eoc_lvl, chain_lvl;

    edge_sync u_sclk (.ref_clk(ref_clk), .resetn(resetn), .pin_in(sclk),
                      .level(sclk_lvl), .rise(), .fall(sclk_fall));
    edge_sync u_cs   (.ref_clk(ref_clk), .resetn(resetn), .pin_in(cs_n),
                      .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
    edge_sync u_sdi  (.ref_clk(ref_clk), .resetn(resetn), .pin_in(sdi),
                      .level(sdi_lvl), .rise(), .fall());
    edge_sync u_cst  (.ref_clk(ref_clk), .resetn(resetn), .pin_in(convert_start_input),
                      .level(), .rise(), .fall(cst_fall));
    edge_sync u_eoc  (.ref_clk(ref_clk), .resetn(resetn), .pin_in(eoc_active),
                      .level(eoc_lvl), .rise(), .fall());
    edge_sync u_chain (.ref_clk(ref_clk), .resetn(resetn), .pin_in(status_pin_in),
                       .level(chain_lvl), .rise(), .fall());

    // ----------------------------------------
    // frame state
    // ----------------------------------------
    reg [11:0] word_ff;
    reg [4:0]  bit_cnt_ff;
    reg [15:0] shift_in_ff;
    reg [15:0] shift_out_ff;
    reg [3:0]  cmd_ff;
    reg        reading_setup_ff;
    reg        after_reset_ff;
    reg [2:0]  trig_cnt_ff;
    reg        eoc_seen_ff;
    reg        chain_ff;

    wire        in_frame  = ~cs_lvl;
    wire [15:0] next_in   = {shift_in_ff[14:0], sdi_lvl};
    wire        last_cmd  = in_frame & sclk_fall & (bit_cnt_ff == `CMD_BITS - 5'd1);
    wire        last_word = in_frame & sclk_fall & (bit_cnt_ff == `FRAME_BITS - 5'd1);
    wire [3:0]  cmd_now   = next_in[3:0];
    // reserved bit 1 forced low on the single-channel part
    wire [11:0] store_val = DUAL_CHANNEL ? next_in[11:0]
                                         : (next_in[11:0] & `SW_RESET_SINGLE);

    always @(posedge ref_clk)
    begin
        if (!resetn || soft_reset)
        begin
            word_ff          <= RESET_WORD;
            bit_cnt_ff       <= 5'd0;
            shift_in_ff      <= 16'h0000;
            shift_out_ff     <= 16'hffff;
            cmd_ff           <= 4'h0;
            reading_setup_ff <= 1'b0;
            after_reset_ff   <= 1'b1;
            chan_sel_valid   <= 1'b0;
            chan_sel         <= 1'b0;
            soft_reset       <= 1'b0;
            sdo              <= 1'b0;
            sdo_oe           <= 1'b0;
        end
        else
        begin
            chan_sel_valid <= 1'b0;
            sdo_oe         <= in_frame;
            if (cs_fall)
            begin
                bit_cnt_ff   <= 5'd0;
                // result is captured at frame start; all ones right after reset
                shift_out_ff <= after_reset_ff ? 16'hffff : result_word;
                sdo          <= after_reset_ff ? 1'b1 : result_word[15];
                // cleared at frame start so a reset inside a frame marks the next one
                after_reset_ff <= 1'b0;
            end
            else if (cs_rise)
            begin
                reading_setup_ff <= 1'b0;
            end
            else if (in_frame && sclk_fall)
            begin
                shift_in_ff <= next_in;
                if (bit_cnt_ff != 5'd31)
                    bit_cnt_ff <= bit_cnt_ff + 5'd1;
                // tag after lsb, zeros after that
                if (bit_cnt_ff == `FRAME_BITS - 5'd1 && tag_en && !reading_setup_ff)
                    sdo <= result_chan;
                else
                    sdo <= shift_out_ff[14];
                shift_out_ff <= {shift_out_ff[14:0], 1'b0};
                if (last_cmd)
                begin
                    cmd_ff <= cmd_now;
                    case (cmd_now)
                        `CMD_SEL_CH0, `CMD_SEL_CH1:
                        begin
                            chan_sel_valid <= DUAL_CHANNEL != 0;
                            chan_sel       <= cmd_now[0];
                        end
                        `CMD_WAKE_UP:
                        begin
                            word_ff[`SW_NAP_OFF]  <= 1'b1;
                            word_ff[`SW_DEEP_OFF] <= 1'b1;
                        end
                        `CMD_READ_SETUP:
                        begin
                            reading_setup_ff <= 1'b1;
                            // four result msbs already out, setup word follows
                            shift_out_ff     <= {word_ff, 4'h0};
                            sdo              <= word_ff[11];
                        end
                        `CMD_DEFAULT:
                            word_ff <= RESET_WORD;
                        default:
                            word_ff <= word_ff;
                    endcase
                end
                if (last_word && cmd_ff == `CMD_WRITE_SETUP)
                begin
                    word_ff    <= store_val;
                    soft_reset <= ~next_in[`SW_NORMAL];
                end
            end
        end
    end

    // ----------------------------------------
    // decoded fields
    // ----------------------------------------
    assign setup_word     = word_ff;
    assign auto_channel   = word_ff[`SW_AUTO_CHAN];
    assign clk_from_osc   = word_ff[`SW_CLK_SEL];
    assign manual_trigger = word_ff[`SW_TRIG_MANUAL];
    assign auto_nap_en    = manual_trigger & ~word_ff[`SW_AUTONAP_OFF];
    assign nap_en         = ~word_ff[`SW_NAP_OFF];
    assign deep_en        = ~word_ff[`SW_DEEP_OFF];
    assign tag_en         = (DUAL_CHANNEL != 0) & word_ff[`SW_TAG_EN];

    // ----------------------------------------
    // conversion start
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            trig_cnt_ff      <= 3'd0;
            eoc_seen_ff      <= 1'b0;
            start_conversion <= 1'b0;
        end
        else
        begin
            start_conversion <= 1'b0;
            if (manual_trigger)
            begin
                trig_cnt_ff <= 3'd0;
                eoc_seen_ff <= 1'b0;
                // start input is ignored during a setup read-back
                if (cst_fall && !reading_setup_ff)
                    start_conversion <= 1'b1;
            end
            else if (eoc_lvl)
            begin
                eoc_seen_ff <= 1'b1;
                trig_cnt_ff <= 3'd0;
            end
            else if (eoc_seen_ff)
            begin
                // counted in reference clocks; core clock is not seen here
                if (trig_cnt_ff == `AUTO_TRIG_DELAY - 3'd1)
                begin
                    start_conversion <= 1'b1;
                    eoc_seen_ff      <= 1'b0;
                    trig_cnt_ff      <= 3'd0;
                end
                else
                    trig_cnt_ff <= trig_cnt_ff + 3'd1;
            end
        end
    end

    // ----------------------------------------
    // multipurpose status pin
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            status_pin_out <= 1'b1;
            status_pin_oe  <= 1'b1;
            chain_ff       <= 1'b0;
        end
        else
        begin
            status_pin_oe  <= word_ff[`SW_PIN_OUTPUT];
            chain_ff       <= chain_lvl;
            if (reading_setup_ff)
                status_pin_out <= word_ff[`SW_POL_LOW];
            else
                status_pin_out <= (word_ff[`SW_FUNC_EOC] ? eoc_active : int_active)
                                  ^ word_ff[`SW_POL_LOW];
        end
    end

    assign chain_data_input = chain_ff & ~word_ff[`SW_PIN_OUTPUT];
endmodule // converter_setup_word

// ### test/converter_setup_word_assertions.sv
// checker for the converter setup word block
`timescale 1ns/1ns
module converter_setup_word_assertions
#(
    parameter DUAL_CHANNEL = 1
)
(
    input wire        ref_clk,
    input wire        resetn,
    input wire        cs_n,
    input wire        sdo_oe,
    input wire        eoc_active,
    input wire        int_active,
    input wire        status_pin_out,
    input wire        status_pin_oe,
    input wire [11:0] setup_word,
    input wire        auto_channel,
    input wire        clk_from_osc,
    input wire        auto_nap_en,
    input wire        nap_en,
    input wire        deep_en,
    input wire        tag_en,
    input wire        soft_reset
);
    wire [11:0] dflt = {10'h3ff, DUAL_CHANNEL != 0, 1'b1};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // decodes may lag the word by a cycle
    sequence s_settled;
        $stable(setup_word)[*2];
    endsequence
    // status pin only judged with the port idle and inputs settled
    sequence s_idle;
        (cs_n && setup_word[5] && $stable({eoc_active, int_active, setup_word}))[*6];
    endsequence
    property p_chan; s_settled |-> auto_channel == setup_word[11]; endproperty
    a_p_chan: assert property (p_chan) else $error("channel mode wrong");
    property p_clk; s_settled |-> clk_from_osc == setup_word[10]; endproperty
    a_p_clk: assert property (p_clk) else $error("clock source wrong");
    property p_anap; s_settled |-> auto_nap_en == (setup_word[9] && !setup_word[4]); endproperty
    a_p_anap: assert property (p_anap) else $error("auto nap wrong");
    property p_nap; s_settled |-> nap_en == !setup_word[3]; endproperty
    a_p_nap: assert property (p_nap) else $error("nap wrong");
    property p_deep; s_settled |-> deep_en == !setup_word[2]; endproperty
    a_p_deep: assert property (p_deep) else $error("deep sleep wrong");
    property p_tag; s_settled |-> tag_en == setup_word[1]; endproperty
    a_p_tag: assert property (p_tag) else $error("tag enable wrong");
    property p_single; DUAL_CHANNEL == 0 |-> !setup_word[1]; endproperty
    a_p_single: assert property (p_single) else $error("tag bit set");
    property p_soft; soft_reset |=> !soft_reset ##[0:1] setup_word == dflt; endproperty
    a_p_soft: assert property (p_soft) else $error("soft reset wrong");
    property p_stat;
        s_idle |-> status_pin_out == ((setup_word[6] ? eoc_active : int_active) ^ setup_word[7]);
    endproperty
    a_p_stat: assert property (p_stat) else $error("status pin wrong");
    property p_pin; s_settled |-> status_pin_oe == setup_word[5]; endproperty
    a_p_pin: assert property (p_pin) else $error("pin direction wrong");
    property p_oe; $stable(cs_n)[*4] ##0 !$past(soft_reset) |-> sdo_oe == !cs_n; endproperty
    a_p_oe: assert property (p_oe) else $error("serial output enable wrong");
endmodule // converter_setup_word_assertions

bind converter_setup_word converter_setup_word_assertions #(.DUAL_CHANNEL(DUAL_CHANNEL)) u_chk
(
    .ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sdo_oe(sdo_oe), .eoc_active(eoc_active),
    .int_active(int_active), .status_pin_out(status_pin_out), .status_pin_oe(status_pin_oe),
    .setup_word(setup_word), .auto_channel(auto_channel), .clk_from_osc(clk_from_osc),
    .auto_nap_en(auto_nap_en), .nap_en(nap_en), .deep_en(deep_en), .tag_en(tag_en),
    .soft_reset(soft_reset)
);

// ### test/serial_host_model.sv
// host processor model on the serial port
`timescale 1ns/1ns
module serial_host_model
(
    input  wire ref_clk,
    output reg  sclk,
    output reg  cs_n,
    output reg  sdi,
    input  wire sdo
);
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi  = 1'b1;
    end
    // slow phases keep sclk well under ref_clk/4; clock stands high between frames
    task xfer(input [15:0] tx, input integer n, output [23:0] rx);
        integer i;
        begin
            rx = 24'h00_0000;
            @(negedge ref_clk) cs_n = 1'b0;
            for (i = 0; i < n; i = i + 1)
            begin
                sdi = (i < 16) ? tx[15 - i] : 1'b0;
                repeat (8) @(negedge ref_clk);
                rx = {rx[22:0], sdo};
                sclk = 1'b0;
                repeat (8) @(negedge ref_clk);
                sclk = 1'b1;
            end
            repeat (4) @(negedge ref_clk);
            cs_n = 1'b1;
            sdi = ~sdi;
            repeat (12) @(negedge ref_clk);
        end
    endtask
endmodule // serial_host_model

// ### test/converter_setup_word_test.sv
// self-checking bench for the converter setup word block
`timescale 1ns/1ns
module converter_setup_word_test;
    reg         ref_clk, resetn, result_chan, eoc_active, int_active;
    reg         convert_start_input, status_pin_in;
    reg  [15:0] result_word;
    reg  [23:0] rx;
    reg  [11:0] w;
    reg  [7:0]  starts = 8'h00;
    reg  [7:0]  sels = 8'h00;
    wire        chan_sel, chan_sel_valid;
    reg  [7:0]  s0;
    integer     err_count = 0, total_checks = 0, k;
    wire        sclk, cs_n, sdi, sdo, start_conversion, chain_data_input;
    wire        auto_channel, clk_from_osc, manual_trigger, auto_nap_en, nap_en, deep_en, tag_en;
    wire [11:0] setup_word;
    localparam [35:0] WORDS = 36'h5_55aa_b36f;

    serial_host_model u_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
    converter_setup_word #(.DUAL_CHANNEL(1)) u_dut
    (
        .ref_clk(ref_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(), .result_word(result_word), .result_chan(result_chan),
        .eoc_active(eoc_active), .int_active(int_active),
        .convert_start_input(convert_start_input), .status_pin_in(status_pin_in),
        .status_pin_out(), .status_pin_oe(), .chain_data_input(chain_data_input),
        .setup_word(setup_word), .auto_channel(auto_channel), .clk_from_osc(clk_from_osc),
        .manual_trigger(manual_trigger), .start_conversion(start_conversion),
        .auto_nap_en(auto_nap_en), .nap_en(nap_en), .deep_en(deep_en), .tag_en(tag_en),
        .soft_reset(), .chan_sel_valid(chan_sel_valid), .chan_sel(chan_sel)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (start_conversion === 1'b1) starts <= starts + 8'h01;
    always @(posedge ref_clk) if (chan_sel_valid === 1'b1) sels <= sels + 8'h01;

    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task cmd(input [3:0] c, input [11:0] d, input integer n);
        u_host.xfer({c, d}, n, rx);
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    initial
    begin
        {resetn, result_chan, eoc_active, int_active} = 4'h0;
        {convert_start_input, status_pin_in} = 2'h3;
        result_word = 16'ha5c3;
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        cmd(4'hc, 12'h000, 16);
        chk(rx[15:0], 16'hffff);
        for (k = 0; k < 3; k = k + 1)
        begin
            w = WORDS[24 - 12 * k +: 12];
            cmd(4'he, w, 16);
            chk({4'h0, setup_word}, {4'h0, w});
            chk({9'h000, auto_channel, clk_from_osc, manual_trigger, auto_nap_en, nap_en,
                 deep_en, tag_en}, {9'h000, w[11:9], w[9] & ~w[4], ~w[3:2], w[1]});
            chk({15'h0000, chain_data_input}, {15'h0000, ~w[5]});
            {eoc_active, int_active} = {k[0], ~k[0]};
            cmd(4'hc, 12'h000, 16);
            chk(rx[15:0], {4'ha, w});
        end
        s0 = starts;
        convert_start_input = 1'b0;
        repeat (6) @(negedge ref_clk);
        convert_start_input = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk({8'h00, starts}, {8'h00, s0 + 8'h01});
        s0 = starts;
        fork
            cmd(4'hc, 12'h000, 16);
            begin
                repeat (60) @(negedge ref_clk);
                convert_start_input = 1'b0;
                repeat (6) @(negedge ref_clk);
                convert_start_input = 1'b1;
            end
        join
        chk({8'h00, starts}, {8'h00, s0});
        result_chan = 1'b1;
        cmd(4'hd, 12'h000, 17);
        chk({15'h0000, rx[0]}, 16'h0001);
        cmd(4'h1, 12'h000, 4);
        chk({15'h0000, chan_sel}, 16'h0001);
        cmd(4'h0, 12'h000, 4);
        chk({15'h0000, chan_sel}, 16'h0000);
        cmd(4'h3, 12'h000, 16);
        chk({4'h0, setup_word}, 16'h036f);
        chk({8'h00, sels}, 16'h0002);
        cmd(4'he, 12'h5ff, 16);
        eoc_active = 1'b1;
        repeat (10) @(negedge ref_clk);
        s0 = starts;
        eoc_active = 1'b0;
        repeat (12) @(negedge ref_clk);
        chk({8'h00, starts}, {8'h00, s0 + 8'h01});
        cmd(4'hf, 12'h000, 4);
        chk({4'h0, setup_word}, 16'h0fff);
        cmd(4'he, 12'hff3, 16);
        cmd(4'hb, 12'h000, 4);
        chk({4'h0, setup_word}, 16'h0fff);
        cmd(4'he, 12'h0f0, 16);
        chk({4'h0, setup_word}, 16'h0fff);
        cmd(4'hc, 12'h000, 16);
        chk(rx[15:0], 16'hffff);
        print_verdict;
    end

    // whole run is near 4200 cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count = err_count + 1;
        print_verdict;
    end
endmodule // converter_setup_word_test
